// [rtl/audio_clock_defs.svh]
// offsets, field positions, reset values and counts of the audio clock block
// assumes inclusion by bare name from the design, checker and bench files
`ifndef AUDIO_CLOCK_DEFS_SVH
`define AUDIO_CLOCK_DEFS_SVH

// register indices; byte address is four times the index
`define IDX_SERIAL_CLOCK_CONTROL 8'h30
`define IDX_CYCLE_STAMP_BYTE0 8'h31
`define IDX_CYCLE_STAMP_BYTE1 8'h32
`define IDX_CYCLE_STAMP_BYTE2 8'h33
`define IDX_REGEN_DIVISOR_BYTE0 8'h34
`define IDX_REGEN_DIVISOR_BYTE1 8'h35
`define IDX_DIVISOR_TOP_FILTER 8'h36
`define IDX_CLEANER_FIFO_STATUS 8'h37

// decode window: haddr[31:5] picks the block, haddr[4:2] the register
`define BLOCK_BASE_HI 27'h0000006

// field positions of the serial clock control register
`define POS_BITS_PER_FRAME_RATIO 7
`define POS_MCLK_RATIO_HI 6
`define POS_MCLK_RATIO_LO 5
`define POS_REF_SEL_HI 4
`define POS_REF_SEL_LO 3
`define POS_CLEAN_MODE_HI 2
`define POS_CLEAN_MODE_LO 1
`define POS_MASTER 0

// field positions of the divisor top and filter register
`define POS_LOOP_FILTER_SHIFT_HI 7
`define POS_LOOP_FILTER_SHIFT_LO 4
`define POS_DIVISOR_TOP_HI 3
`define POS_DIVISOR_TOP_LO 0

// field positions of the cleaner status register
`define POS_IN_FILL_HI 5
`define POS_IN_FILL_LO 3
`define POS_OUT_FILL_HI 2
`define POS_OUT_FILL_LO 0

// reset values
`define RST_BYTE_REG 8'h00

// bit-clock periods per half frame: 64 or 32 per frame
`define HALF_FRAME_64 6'h20
`define HALF_FRAME_32 6'h10

// cleaner constants
`define FILL_MAX 3'h7
`define FILL_TARGET 3'h4
`define NCO_STEP_INIT 16'h4000
`define NCO_STEP_MIN 16'h0100
`define NCO_STEP_MAX 16'hff00

`endif

// [rtl/audio_clock_pkg.sv]
// types shared by the audio clock block and its cleaner
// assumes the defs header is on the include path
package audio_clock_pkg;

   // serial clock control register layout, msb first
   typedef struct packed {
      logic bits_per_frame_ratio;
      logic [1:0] mclk_ratio;
      logic [1:0] ref_sel;
      logic [1:0] clean_mode;
      logic master;
   } serial_clock_control_t;

   // settings handed to the cleaner
   typedef struct packed {
      logic [1:0] clean_mode;
      logic [3:0] loop_filter_shift;
   } cleaner_cfg_t;

   // live fill levels coming back from the cleaner
   typedef struct packed {
      logic [2:0] cleaner_input_fill;
      logic [2:0] cleaner_output_fill;
   } cleaner_fill_t;

endpackage

// [rtl/clock_cleaner.sv]
// digital clock cleaner: input fifo, nco on the reference, output fifo
// assumes single-cycle event pulses synchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "audio_clock_defs.svh"

module clock_cleaner (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic src_evt,
   input wire logic ref_tick,
   input wire audio_clock_pkg::cleaner_cfg_t cfg,
   output logic clean_evt,
   output audio_clock_pkg::cleaner_fill_t fill
);
   import audio_clock_pkg::*;

   typedef enum {ST_BYPASS, ST_CLEAN} clean_state_t;

   clean_state_t state_q;
   logic [1:0] pre_q;
   logic [2:0] in_q, out_q;
   logic [15:0] acc_q, step_q;
   logic clean_evt_q;

   // ratio 1, 2 or 4 source events per fifo entry
   wire cleaning = (cfg.clean_mode != 2'b00);
   wire [1:0] pre_last = (cfg.clean_mode == 2'b01) ? 2'd0 :
                         (cfg.clean_mode == 2'b10) ? 2'd1 : 2'd3;
   wire push_in = src_evt && (pre_q == pre_last) && (in_q != `FILL_MAX);
   wire [16:0] acc_sum = {1'b0, acc_q} + {1'b0, step_q};
   wire carry = ref_tick && acc_sum[16];
   wire move = carry && (in_q != 3'h0) && (out_q != `FILL_MAX);
   wire drain = ref_tick && (out_q != 3'h0);
   // feedback on fill error, divided by two to the shift
   wire signed [17:0] err = $signed({15'h0, in_q}) - $signed({15'h0, `FILL_TARGET});
   wire signed [17:0] corr = (err <<< 8) >>> cfg.loop_filter_shift;
   wire signed [17:0] step_raw = $signed({2'b00, step_q}) + corr;
   wire [15:0] step_lim = (step_raw < $signed({2'b00, `NCO_STEP_MIN})) ? `NCO_STEP_MIN :
                          (step_raw > $signed({2'b00, `NCO_STEP_MAX})) ? `NCO_STEP_MAX :
                          step_raw[15:0];

   // mode tracking
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) state_q <= ST_BYPASS;
      else begin
         case (state_q)
            ST_BYPASS: if (cleaning) state_q <= ST_CLEAN;
            ST_CLEAN: if (!cleaning) state_q <= ST_BYPASS;
            default: state_q <= ST_BYPASS;
         endcase
      end
   end

   // prescaler and fifo levels, cleared while bypassed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_q <= 2'd0;
         in_q <= 3'h0;
         out_q <= 3'h0;
      end else if (state_q != ST_CLEAN) begin
         pre_q <= 2'd0;
         in_q <= 3'h0;
         out_q <= 3'h0;
      end else begin
         if (src_evt) pre_q <= (pre_q == pre_last) ? 2'd0 : pre_q + 2'd1;
         in_q <= in_q + {2'b00, push_in} - {2'b00, move};
         out_q <= out_q + {2'b00, move} - {2'b00, drain};
      end
   end

   // nco and loop filter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= 16'h0000;
         step_q <= `NCO_STEP_INIT;
      end else begin
         if (ref_tick) acc_q <= acc_sum[15:0];
         if (carry) step_q <= step_lim;
      end
   end

   // output event: cleaned drain or straight through
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) clean_evt_q <= 1'b0;
      else clean_evt_q <= (state_q == ST_CLEAN) ? drain : src_evt;
   end

   assign clean_evt = clean_evt_q;
   assign fill.cleaner_input_fill = in_q;
   assign fill.cleaner_output_fill = out_q;

endmodule
`default_nettype wire

// [rtl/audio_clock_gen_cleaner.sv]
// audio clock generation and cleaning block with an ahb-lite register slave
// assumes vco and oscillator ticks and pin inputs synchronous to hclk
`timescale 1ns/1ps
`default_nettype none
`include "audio_clock_defs.svh"

// Behaviour
// - frame control bit clear: 64 bit clocks per frame; set: 32
// - master-clock to bit-clock ratio code 00:4, 01:2, 10:1, 11:8
// - nonzero cleaner mode cleans the source clock, ratio 1, 2 or 4
// - cleaner reference is vco divided by 8, 4, 2, or the oscillator
// - master bit drives bit-clock and frame pins and enables generation
// - 24-bit stamp over three bytes, lsb first; nonzero enables synthesis
// - 20-bit divisor over two bytes and a low nibble, feeds synthesis
// - cleaner feedback divided by two to the four-bit shift field
// - input fifo fill level readable at bits 5:3, resets to zero
// - output fifo fill level readable at bits 2:0, resets to zero
module audio_clock_gen_cleaner (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic link_pll_vco_clock,
   input wire logic always_on_oscillator,
   input wire logic bit_clock_i,
   output logic bit_clock_o,
   output logic bit_clock_oe,
   input wire logic frame_select_pin_i,
   output logic frame_select_pin_o,
   output logic frame_select_pin_oe,
   output logic master_clock_o,
   output logic recovered_clock_o
);
   import audio_clock_pkg::*;

   // registers
   serial_clock_control_t ctrl_q;
   logic [23:0] stamp_q;
   logic [19:0] divisor_q;
   logic [3:0] loop_filter_shift_q;

   // bus data-phase state
   logic wr_pend_q;
   logic [2:0] wr_idx_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q;
   logic hresp_q;

   // clock path state
   logic [2:0] ref_cnt_q;
   logic [24:0] synth_acc_q;
   logic bclk_prev_q;
   logic [2:0] mdiv_q;
   logic [5:0] half_cnt_q;
   logic mclk_q, bclk_q, fs_q, rec_q;
   logic bclk_oe_q, fs_oe_q;
   logic fs_seen_q;

   wire clean_evt;
   cleaner_fill_t fill;
   cleaner_cfg_t cfg;

   // address decode and byte lanes
   wire addr_hit = (haddr[31:5] == `BLOCK_BASE_HI);
   wire [2:0] addr_idx = haddr[4:2];
   wire take = hsel && hready && htrans[1];
   wire take_wr = take && hwrite && addr_hit;
   wire take_rd = take && !hwrite;
   wire [7:0] wbyte = hwdata[7:0];

   // write strobes per register in the data phase
   wire [7:0] idx_ctrl = `IDX_SERIAL_CLOCK_CONTROL;
   wire [7:0] idx_cts0 = `IDX_CYCLE_STAMP_BYTE0;
   wire [7:0] idx_cts1 = `IDX_CYCLE_STAMP_BYTE1;
   wire [7:0] idx_cts2 = `IDX_CYCLE_STAMP_BYTE2;
   wire [7:0] idx_n0 = `IDX_REGEN_DIVISOR_BYTE0;
   wire [7:0] idx_n1 = `IDX_REGEN_DIVISOR_BYTE1;
   wire [7:0] idx_top = `IDX_DIVISOR_TOP_FILTER;
   wire [7:0] idx_sts = `IDX_CLEANER_FIFO_STATUS;
   wire we_ctrl = wr_pend_q && (wr_idx_q == idx_ctrl[2:0]);
   wire we_cts0 = wr_pend_q && (wr_idx_q == idx_cts0[2:0]);
   wire we_cts1 = wr_pend_q && (wr_idx_q == idx_cts1[2:0]);
   wire we_cts2 = wr_pend_q && (wr_idx_q == idx_cts2[2:0]);
   wire we_n0 = wr_pend_q && (wr_idx_q == idx_n0[2:0]);
   wire we_n1 = wr_pend_q && (wr_idx_q == idx_n1[2:0]);
   wire we_top = wr_pend_q && (wr_idx_q == idx_top[2:0]);

   // register read view, status built from live fill levels
   wire [7:0] status_view = {2'b00, fill.cleaner_input_fill,
                             fill.cleaner_output_fill};
   wire [7:0] top_view = {loop_filter_shift_q, divisor_q[19:16]};
   wire [7:0] rd_byte =
      (addr_idx == idx_ctrl[2:0]) ? ctrl_q :
      (addr_idx == idx_cts0[2:0]) ? stamp_q[7:0] :
      (addr_idx == idx_cts1[2:0]) ? stamp_q[15:8] :
      (addr_idx == idx_cts2[2:0]) ? stamp_q[23:16] :
      (addr_idx == idx_n0[2:0]) ? divisor_q[7:0] :
      (addr_idx == idx_n1[2:0]) ? divisor_q[15:8] :
      (addr_idx == idx_top[2:0]) ? top_view : status_view;
   // a read right behind a write to the same register sees the new byte, except at the status register
   wire fwd = wr_pend_q && (wr_idx_q == addr_idx) && (addr_idx != idx_sts[2:0]);
   wire [7:0] rd_sel = fwd ? wbyte : rd_byte;
   wire [31:0] rd_word = addr_hit ? {24'h000000, rd_sel} : 32'h00000000;

   // bus phase tracking; always ready, always okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_idx_q <= 3'h0;
         hrdata_q <= 32'h00000000;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end else begin
         wr_pend_q <= take_wr;
         if (take_wr) wr_idx_q <= addr_idx;
         if (take_rd) hrdata_q <= rd_word;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end
   end

   // control register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) ctrl_q <= `RST_BYTE_REG;
      else if (we_ctrl) ctrl_q <= wbyte;
   end

   // cycle stamp bytes, least significant first
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) stamp_q <= {3{`RST_BYTE_REG}};
      else begin
         if (we_cts0) stamp_q[7:0] <= wbyte;
         if (we_cts1) stamp_q[15:8] <= wbyte;
         if (we_cts2) stamp_q[23:16] <= wbyte;
      end
   end

   // divisor bytes, top nibble shares a register with the filter shift
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         divisor_q <= 20'h00000;
         loop_filter_shift_q <= 4'h0;
      end else begin
         if (we_n0) divisor_q[7:0] <= wbyte;
         if (we_n1) divisor_q[15:8] <= wbyte;
         if (we_top) begin
            divisor_q[19:16] <= wbyte[`POS_DIVISOR_TOP_HI:`POS_DIVISOR_TOP_LO];
            loop_filter_shift_q <=
               wbyte[`POS_LOOP_FILTER_SHIFT_HI:`POS_LOOP_FILTER_SHIFT_LO];
         end
      end
   end

   // cleaner reference: vco divided by 8, 4, 2 or the oscillator
   wire [2:0] ref_last = (ctrl_q.ref_sel == 2'b00) ? 3'd7 :
                         (ctrl_q.ref_sel == 2'b01) ? 3'd3 : 3'd1;
   wire use_osc = (ctrl_q.ref_sel == 2'b11);
   wire vco_wrap = link_pll_vco_clock && (ref_cnt_q >= ref_last);
   wire ref_tick = use_osc ? always_on_oscillator : vco_wrap;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) ref_cnt_q <= 3'd0;
      else if (link_pll_vco_clock) ref_cnt_q <= vco_wrap ? 3'd0 : ref_cnt_q + 3'd1;
   end

   // synthesis from the vco: stamp/divisor fractional divider
   // divisor must stay below the stamp or the accumulator runs away
   wire synth_on = ctrl_q.master && (stamp_q != 24'h000000);
   wire [24:0] synth_sum = synth_acc_q + {5'h00, divisor_q};
   wire synth_hit = synth_sum >= {1'b0, stamp_q};
   wire synth_evt = synth_on && link_pll_vco_clock && synth_hit;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) synth_acc_q <= 25'h0000000;
      else if (!synth_on) synth_acc_q <= 25'h0000000;
      else if (link_pll_vco_clock)
         synth_acc_q <= synth_hit ? synth_sum - {1'b0, stamp_q} : synth_sum;
   end

   // received bit clock rising edge, used when not master
   wire rx_evt = !ctrl_q.master && bit_clock_i && !bclk_prev_q;
   wire src_evt = ctrl_q.master ? synth_evt : rx_evt;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) bclk_prev_q <= 1'b0;
      else bclk_prev_q <= bit_clock_i;
   end

   assign cfg.clean_mode = ctrl_q.clean_mode;
   assign cfg.loop_filter_shift = loop_filter_shift_q;

   // cleaner
   clock_cleaner u_cleaner (
      .clk(hclk),
      .rst_n(hresetn),
      .src_evt(src_evt),
      .ref_tick(ref_tick),
      .cfg(cfg),
      .clean_evt(clean_evt),
      .fill(fill)
   );

   // master clock toggles per event; bit clock every 4, 2, 1 or 8 events
   wire [2:0] mdiv_last = (ctrl_q.mclk_ratio == 2'b00) ? 3'd3 :
                          (ctrl_q.mclk_ratio == 2'b01) ? 3'd1 :
                          (ctrl_q.mclk_ratio == 2'b10) ? 3'd0 : 3'd7;
   wire gen_evt = ctrl_q.master && clean_evt;
   wire bclk_toggle = gen_evt && (mdiv_q >= mdiv_last);
   wire bclk_fall = bclk_toggle && bclk_q;
   wire [5:0] half_last = ctrl_q.bits_per_frame_ratio ? `HALF_FRAME_32 - 6'd1 :
                          `HALF_FRAME_64 - 6'd1;
   wire fs_toggle = bclk_fall && (half_cnt_q >= half_last);

   // master clock and bit clock dividers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mclk_q <= 1'b0;
         mdiv_q <= 3'd0;
         bclk_q <= 1'b0;
      end else if (!ctrl_q.master) begin
         mclk_q <= 1'b0;
         mdiv_q <= 3'd0;
         bclk_q <= 1'b0;
      end else if (gen_evt) begin
         mclk_q <= !mclk_q;
         mdiv_q <= bclk_toggle ? 3'd0 : mdiv_q + 3'd1;
         if (bclk_toggle) bclk_q <= !bclk_q;
      end
   end

   // frame select: changes after each half frame of bit clocks
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         half_cnt_q <= 6'd0;
         fs_q <= 1'b0;
      end else if (!ctrl_q.master) begin
         half_cnt_q <= 6'd0;
         fs_q <= 1'b0;
      end else if (bclk_fall) begin
         half_cnt_q <= fs_toggle ? 6'd0 : half_cnt_q + 6'd1;
         if (fs_toggle) fs_q <= !fs_q;
      end
   end

   // pin directions follow the master bit; recovered clock per cleaned event
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bclk_oe_q <= 1'b0;
         fs_oe_q <= 1'b0;
         rec_q <= 1'b0;
         fs_seen_q <= 1'b0;
      end else begin
         bclk_oe_q <= ctrl_q.master;
         fs_oe_q <= ctrl_q.master;
         if (clean_evt) rec_q <= !rec_q;
         fs_seen_q <= frame_select_pin_i;
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;
   assign bit_clock_o = bclk_q;
   assign bit_clock_oe = bclk_oe_q;
   assign frame_select_pin_o = fs_q;
   assign frame_select_pin_oe = fs_oe_q;
   assign master_clock_o = mclk_q;
   assign recovered_clock_o = rec_q;

endmodule
`default_nettype wire

// [sim/audio_clock_gen_cleaner_checker.sv]
// checker of the audio clock block, watching its top ports only
// assumes a bind onto audio_clock_gen_cleaner and the defs header on the path
`timescale 1ns/1ps
`default_nettype none
`include "audio_clock_defs.svh"
module audio_clock_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic bit_clock_o,
   input wire logic bit_clock_oe,
   input wire logic frame_select_pin_o,
   input wire logic frame_select_pin_oe,
   input wire logic master_clock_o,
   input wire logic recovered_clock_o
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // decode of taken transfers
   wire take = hsel && hready && htrans[1];
   wire at_ctrl = haddr == {22'h0, `IDX_SERIAL_CLOCK_CONTROL, 2'b00};
   wire at_stat = haddr == {22'h0, `IDX_CLEANER_FIFO_STATUS, 2'b00};
   logic wr_q;
   logic mclk_q;
   logic rec_q;
   logic [7:0] ctrl_q;
   wire mtog = master_clock_o ^ mclk_q;
   wire rtog = recovered_clock_o ^ rec_q;
   // shadow of the control byte and last clock levels
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         ctrl_q <= 8'h00;
         mclk_q <= 1'b0;
         rec_q <= 1'b0;
      end else begin
         if (hready) wr_q <= take && hwrite && at_ctrl;
         if (wr_q && hready) ctrl_q <= hwdata[7:0];
         mclk_q <= master_clock_o;
         rec_q <= recovered_clock_o;
      end
   end
   sequence s_rd_ctrl; take && !hwrite && at_ctrl; endsequence
   sequence s_rd_stat; take && !hwrite && at_stat; endsequence
   property p_oe_master; bit_clock_oe == $past(ctrl_q[0]); endproperty
   a_oe_master: assert property (p_oe_master)
      else $error("pin enable does not follow master bit");
   property p_fs_oe; frame_select_pin_oe == bit_clock_oe; endproperty
   a_fs_oe: assert property (p_fs_oe)
      else $error("frame pin enable differs from bit clock enable");
   property p_upper_zero; hrdata[31:8] == 24'h0; endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("read data above the byte not zero");
   property p_ctrl_back; s_rd_ctrl |=> hrdata[7:0] == ctrl_q; endproperty
   a_ctrl_back: assert property (p_ctrl_back)
      else $error("control byte read back wrong");
   property p_stat_resv; s_rd_stat |=> hrdata[7:6] == 2'b00; endproperty
   a_stat_resv: assert property (p_stat_resv)
      else $error("status top bits not zero");
   property p_rd_hold; !(take && !hwrite) |=> $stable(hrdata); endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data moved without a read");
   property p_slave_quiet;
      (!bit_clock_oe)[*3] |-> !bit_clock_o && !frame_select_pin_o && !master_clock_o;
   endproperty
   a_slave_quiet: assert property (p_slave_quiet)
      else $error("clock outputs move while not master");
   property p_mclk_rec; bit_clock_oe[*3] |-> mtog == rtog; endproperty
   a_mclk_rec: assert property (p_mclk_rec)
      else $error("master clock and recovered clock out of step");
endmodule
`default_nettype wire

// [sim/audio_serial_partner.sv]
// serial audio partner: bit clock and frame source, half-frame length sink
// assumes one clock shared with the block; the bench resolves wire levels
`timescale 1ns/1ps
`default_nettype none
module audio_serial_partner #(parameter int HALF_BITS = 32) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic bck_wire,
   input wire logic fs_wire,
   output logic bck_drv,
   output logic fs_drv,
   output logic [7:0] half_bits
);
   logic [1:0] div_q;
   logic [7:0] src_q;
   logic [7:0] cnt_q;
   logic bck_q;
   logic fs_q;
   wire bck_fall = bck_q & ~bck_wire;
   wire fs_edge = fs_q ^ fs_wire;
   wire [7:0] seen = cnt_q + {7'h0, bck_fall};
   // source clocks; released lines toggle since nothing pulls them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= 2'h0;
         src_q <= 8'h00;
         bck_drv <= 1'b0;
         fs_drv <= 1'b0;
      end else begin
         div_q <= div_q + 2'h1;
         if (!run) begin
            bck_drv <= ~bck_drv;
            fs_drv <= ~fs_drv;
         end else if (div_q == 2'h3) begin
            bck_drv <= ~bck_drv;
            if (bck_drv) src_q <= (src_q == 8'(HALF_BITS - 1)) ? 8'h00 : src_q + 8'h01;
            if (bck_drv && src_q == 8'(HALF_BITS - 1)) fs_drv <= ~fs_drv;
         end
      end
   end
   // sink: bit clock falls between frame select edges
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bck_q <= 1'b0;
         fs_q <= 1'b0;
         cnt_q <= 8'h00;
         half_bits <= 8'h00;
      end else begin
         bck_q <= bck_wire;
         fs_q <= fs_wire;
         cnt_q <= fs_edge ? 8'h00 : seen;
         if (fs_edge) half_bits <= seen;
      end
   end
endmodule
`default_nettype wire

// [sim/audio_clock_gen_cleaner_tb.sv]
// bench of the audio clock block: bus tasks, partner, rate counters
// assumes the defs header on the path and hready looped from hreadyout
`timescale 1ns/1ps
`default_nettype none
`include "audio_clock_defs.svh"
module audio_clock_gen_cleaner_tb;
   logic hclk, hresetn, hsel, hwrite, vco, aon, aon_en, run;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp, bck_o, bck_oe, fs_o, fs_oe, mclk, rec, p_bck, p_fs;
   logic pm, pb, pf, pr;
   logic [7:0] half_bits;
   int n_fail, n_compared, m_since, m_per_b, b_cnt, f_cnt, r_cnt, c1, i, j;
   // pin levels from whoever drives them
   wire bck = bck_oe ? bck_o : p_bck;
   wire fs = fs_oe ? fs_o : p_fs;
   audio_clock_gen_cleaner dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link_pll_vco_clock(vco),
      .always_on_oscillator(aon), .bit_clock_i(bck), .bit_clock_o(bck_o),
      .bit_clock_oe(bck_oe), .frame_select_pin_i(fs), .frame_select_pin_o(fs_o),
      .frame_select_pin_oe(fs_oe), .master_clock_o(mclk), .recovered_clock_o(rec));
   audio_serial_partner sp (.clk(hclk), .rst_n(hresetn), .run(run), .bck_wire(bck),
      .fs_wire(fs), .bck_drv(p_bck), .fs_drv(p_fs), .half_bits(half_bits));
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // oscillator tick every other cycle when enabled
   always @(posedge hclk) aon <= aon_en & ~aon;
   // toggle counters on settled outputs
   always @(negedge hclk) begin
      if (rec !== pr) r_cnt++;
      if (mclk !== pm) m_since++;
      if (fs !== pf) f_cnt++;
      if (bck_o !== pb) begin
         m_per_b = m_since;
         m_since = 0;
         b_cnt++;
      end
      {pm, pb, pf, pr} = {mclk, bck_o, fs, rec};
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic wait_cnt(ref int c, input int n);
      int k, b;
      b = c;
      for (k = 0; k < 4000 && c < b + n; k++) @(posedge hclk);
      if (c < b + n) begin
         n_fail++;
         conclude();
      end
   endtask
   task automatic wait_ready();
      int k;
      k = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         k++;
         if (k > 20) begin
            n_fail++;
            conclude();
         end
         @(posedge hclk);
      end
   endtask
   // one single transfer: address phase, then data phase
   task automatic bus(input logic [7:0] idx, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'b00};
      htrans <= 2'h2;
      hwrite <= w;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      bus(idx, 1'b1, {24'h0, v});
   endtask
   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
      bus(idx, 1'b0, 32'h0);
      check(rd, exp);
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge hclk);
   endtask
   initial begin
      {hsel, hwrite, hresetn, run, aon_en, vco} = 6'h01;
      {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
      cycles(6);
      hresetn <= 1'b1;
      for (i = 0; i < 8; i++) rd_chk(`IDX_SERIAL_CLOCK_CONTROL + i[7:0], 32'h0);
      // every writable byte read straight after its write
      for (i = 0; i < 7; i++) begin
         wr(`IDX_SERIAL_CLOCK_CONTROL + i[7:0], 8'h5a + i[7:0]);
         rd_chk(`IDX_SERIAL_CLOCK_CONTROL + i[7:0], 32'h5a + i);
      end
      wr(8'h38, 8'hff);
      rd_chk(8'h38, 32'h0);
      // slave source, silent reference: input fifo saturates
      run <= 1'b1;
      wr(`IDX_SERIAL_CLOCK_CONTROL, 8'h1a);
      cycles(200);
      wr(`IDX_CLEANER_FIFO_STATUS, 8'h00);
      rd_chk(`IDX_CLEANER_FIFO_STATUS, 32'h38);
      check({31'h0, bck_oe}, 32'h0);
      wr(`IDX_SERIAL_CLOCK_CONTROL, 8'h18);
      // mode change reaches the cleaner state, then clears the fifos
      cycles(2);
      rd_chk(`IDX_CLEANER_FIFO_STATUS, 32'h0);
      // master with zero stamp: no synthesis
      run <= 1'b0;
      for (i = 0; i < 6; i++) wr(`IDX_CYCLE_STAMP_BYTE0 + i[7:0], (i == 3) ? 8'h01 : 8'h00);
      wr(`IDX_SERIAL_CLOCK_CONTROL, 8'h01);
      cycles(4);
      check({30'h0, bck_oe, fs_oe}, 32'h3);
      c1 = r_cnt;
      cycles(100);
      check(r_cnt - c1, 32'h0);
      // event rate is divisor over stamp per vco tick
      wr(`IDX_CYCLE_STAMP_BYTE0, 8'h04);
      c1 = r_cnt;
      cycles(400);
      j = r_cnt - c1;
      check({31'h0, j inside {[96:104]}}, 32'h1);
      wr(`IDX_REGEN_DIVISOR_BYTE0, 8'h02);
      c1 = r_cnt;
      cycles(400);
      check({31'h0, (r_cnt - c1 - 2 * j) inside {[-4:4]}}, 32'h1);
      // master clock events per bit clock edge for every code, then half-frame length for both frame settings
      wr(`IDX_CYCLE_STAMP_BYTE0, 8'h02);
      wr(`IDX_REGEN_DIVISOR_BYTE0, 8'h01);
      for (i = 0; i < 4; i++) begin
         wr(`IDX_SERIAL_CLOCK_CONTROL, {1'b0, i[1:0], 5'h01});
         wait_cnt(b_cnt, 4);
         check(m_per_b, (i == 3) ? 32'h8 : 32'h4 >> i);
      end
      for (i = 0; i < 2; i++) begin
         wr(`IDX_SERIAL_CLOCK_CONTROL, {i[0], 2'b10, 5'h01});
         wait_cnt(f_cnt, 3);
         check({24'h0, half_bits}, (i == 1) ? 32'h10 : 32'h20);
      end
      // every nonzero cleaner mode against every reference
      aon_en <= 1'b1;
      wr(`IDX_DIVISOR_TOP_FILTER, 8'h30);
      for (i = 1; i < 4; i++) begin
         for (j = 0; j < 4; j++) begin
            wr(`IDX_SERIAL_CLOCK_CONTROL, {3'b010, j[1:0], i[1:0], 1'b1});
            c1 = r_cnt;
            cycles(300);
            check({31'h0, r_cnt > c1}, 32'h1);
         end
      end
      // second reset in mid-run
      hresetn <= 1'b0;
      cycles(2);
      hresetn <= 1'b1;
      rd_chk(`IDX_SERIAL_CLOCK_CONTROL, 32'h0);
      check({30'h0, bck_oe, fs_oe}, 32'h0);
      conclude();
   end
endmodule
bind audio_clock_gen_cleaner audio_clock_checker chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hwdata, .hready, .hrdata, .bit_clock_o, .bit_clock_oe, .frame_select_pin_o,
   .frame_select_pin_oe, .master_clock_o, .recovered_clock_o);
`default_nettype wire
